// >>> verilog/mailbox_pkg.sv
`default_nettype none
package mailbox_pkg;

   localparam int unsigned HALF_W = 16;
   localparam int unsigned WORD_W = 32;

   // core register indices in the core's register space
   localparam logic [5:0] REG_DATA_HIGH = 6'h28;
   localparam logic [5:0] REG_DATA_LOW  = 6'h29;
   localparam int unsigned REG_ADDR_W   = 6;

   // positions in the external-state signal set
   localparam int unsigned EXT_STATE_W        = 8;
   localparam int unsigned EXT_STATE_BIT_SIX   = 6;
   localparam int unsigned EXT_STATE_BIT_SEVEN = 7;

   localparam logic        FLAG_RESET = 1'b0;
   localparam logic [15:0] HALF_RESET = 16'h0000;

endpackage

`default_nettype wire

// >>> verilog/mailbox_half.sv
`timescale 1ns/10ps
`default_nettype none

// one 16-bit slice of both directions of the mailbox
module mailbox_half #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             host_wr_in,
   input  wire logic [WIDTH-1:0] host_data_in,
   input  wire logic             core_wr_in,
   input  wire logic [WIDTH-1:0] core_data_in,
   output logic      [WIDTH-1:0] inbound_out,
   output logic      [WIDTH-1:0] outbound_out
);

   typedef struct packed {
      logic [WIDTH-1:0] inbound;
      logic [WIDTH-1:0] outbound;
   } half_state_t;

   half_state_t state_q;
   half_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      if (host_wr_in)
      begin
         state_d.inbound = host_data_in;
      end
      if (core_wr_in)
      begin
         state_d.outbound = core_data_in;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign inbound_out  = state_q.inbound;
   assign outbound_out = state_q.outbound;

endmodule

`default_nettype wire

// >>> verilog/host_core_mailbox.sv
// How it works
// - the 32-bit mailbox is two 16-bit core registers, high and low halves
// - host write loads inbound word; host read returns outbound word
// - inbound pending rises on host write, stays until core reads high half
// - core read of high half clears inbound pending
// - core write of high half sets outbound pending until host reads
// - host read of the mailbox clears outbound pending
// - inbound pending visible to core as external-state bit six
// - outbound pending visible to core as external-state bit seven
// - both pending flags are driven out as pins
// - low-half core accesses never change either flag
// - core software touches low half first, high half last
// - a nullified core read of high half still clears inbound pending
`timescale 1ns/10ps
`default_nettype none

module host_core_mailbox #(
   parameter int unsigned WORD_W = mailbox_pkg::WORD_W,
   parameter int unsigned HALF_W = mailbox_pkg::HALF_W,
   parameter int unsigned ADDR_W = mailbox_pkg::REG_ADDR_W,
   parameter int unsigned EXT_W  = mailbox_pkg::EXT_STATE_W
) (
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   input  wire logic              mailbox_select_in,
   input  wire logic              host_wr_in,
   input  wire logic              host_rd_in,
   input  wire logic [WORD_W-1:0] host_wdata_in,
   output logic      [WORD_W-1:0] host_rdata_out,
   input  wire logic              core_wr_in,
   input  wire logic              core_rd_in,
   input  wire logic              core_nullified_in,
   input  wire logic [ADDR_W-1:0] core_addr_in,
   input  wire logic [HALF_W-1:0] core_wdata_in,
   output logic      [HALF_W-1:0] core_rdata_out,
   output logic      [EXT_W-1:0]  ext_state_out,
   output logic                   inbound_pending_pin_out,
   output logic                   outbound_pending_pin_out
);

   // the word splits into core-sized halves; index 0 is the low half
   localparam int unsigned HALVES = WORD_W / HALF_W;
   localparam int unsigned TOP    = HALVES - 1;

   typedef struct packed {
      logic              inbound_pending;
      logic              outbound_pending;
      logic [EXT_W-1:0]  ext_state;
      logic [WORD_W-1:0] host_rdata;
      logic [HALF_W-1:0] core_rdata;
   } top_state_t;

   top_state_t state_q;
   top_state_t state_d;

   logic [HALVES-1:0]             core_sel;
   logic [HALVES-1:0]             core_half_wr;
   logic [HALVES-1:0][HALF_W-1:0] in_half;
   logic [HALVES-1:0][HALF_W-1:0] out_half;
   logic                          host_wr;
   logic                          host_rd;
   logic                          core_wr_eff;
   logic                          inbound_take;
   logic                          inbound_consume;
   logic                          outbound_post;
   logic                          outbound_take;

   // core register index that reaches a given half
   function automatic logic [ADDR_W-1:0] half_index(
      input int unsigned half
   );
      if (half == 0)
      begin
         return ADDR_W'(mailbox_pkg::REG_DATA_LOW);
      end
      else
      begin
         return ADDR_W'(mailbox_pkg::REG_DATA_HIGH);
      end
   endfunction

   function automatic logic hits_index(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] index
   );
      return addr == index;
   endfunction

   // a raise in the same cycle as a drop wins, so a fresh word is never lost
   function automatic logic next_flag(
      input logic current,
      input logic raise,
      input logic drop
   );
      logic result;
      result = current;
      if (drop)
      begin
         result = 1'b0;
      end
      if (raise)
      begin
         result = 1'b1;
      end
      return result;
   endfunction

   // external-state image of the two flags; all other bits read as zero
   function automatic logic [EXT_W-1:0] ext_state_of(
      input logic inbound,
      input logic outbound
   );
      logic [EXT_W-1:0] image;
      image = '0;
      image[mailbox_pkg::EXT_STATE_BIT_SIX]   = inbound;
      image[mailbox_pkg::EXT_STATE_BIT_SEVEN] = outbound;
      return image;
   endfunction

   // host side reaches the mailbox only while select is asserted
   assign host_wr = mailbox_select_in & host_wr_in;
   assign host_rd = mailbox_select_in & host_rd_in;
   // a nullified write stores nothing
   assign core_wr_eff = core_wr_in & ~core_nullified_in;

   // both halves are written together by a 32-bit host transfer
   for (genvar i = 0; i < HALVES; i++)
   begin : g_half
      assign core_sel[i]     = hits_index(core_addr_in, half_index(i));
      assign core_half_wr[i] = core_wr_eff & core_sel[i];

      mailbox_half #(
         .WIDTH(HALF_W)
      ) u_half (
         .clock_in     (clock_in),
         .rst_in       (rst_in),
         .host_wr_in   (host_wr),
         .host_data_in (host_wdata_in[i*HALF_W +: HALF_W]),
         .core_wr_in   (core_half_wr[i]),
         .core_data_in (core_wdata_in),
         .inbound_out  (in_half[i]),
         .outbound_out (out_half[i])
      );
   end

   // only the high half moves the flags; low half accesses pass data only
   assign inbound_take    = host_wr;
   // a nullified read still consumes the word, so such slots must be avoided
   assign inbound_consume = core_rd_in & core_sel[TOP];
   assign outbound_post   = core_half_wr[TOP];
   assign outbound_take   = host_rd;

   always_comb
   begin
      state_d = state_q;
      // the host sees the outbound word as it stands in the read cycle
      if (host_rd)
      begin
         state_d.host_rdata = out_half;
      end
      for (int unsigned i = 0; i < HALVES; i++)
      begin
         if (core_rd_in & core_sel[i])
         begin
            state_d.core_rdata = in_half[i];
         end
      end
      state_d.inbound_pending  = next_flag(state_q.inbound_pending,
                                           inbound_take,
                                           inbound_consume);
      state_d.outbound_pending = next_flag(state_q.outbound_pending,
                                           outbound_post,
                                           outbound_take);
      state_d.ext_state        = ext_state_of(state_d.inbound_pending,
                                              state_d.outbound_pending);
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q.inbound_pending  <= mailbox_pkg::FLAG_RESET;
         state_q.outbound_pending <= mailbox_pkg::FLAG_RESET;
         state_q.ext_state        <= '0;
         state_q.host_rdata       <= '0;
         state_q.core_rdata       <= HALF_W'(mailbox_pkg::HALF_RESET);
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // host must poll this before writing again
   assign inbound_pending_pin_out  = state_q.inbound_pending;
   assign outbound_pending_pin_out = state_q.outbound_pending;
   assign host_rdata_out           = state_q.host_rdata;
   assign core_rdata_out           = state_q.core_rdata;
   assign ext_state_out            = state_q.ext_state;

endmodule

`default_nettype wire

// >>> tb/mailbox_sva.sv
`timescale 1ns/10ps
`default_nettype none
module mailbox_sva (
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       mailbox_select_in,
   input wire logic       host_wr_in,
   input wire logic       host_rd_in,
   input wire logic       core_wr_in,
   input wire logic       core_rd_in,
   input wire logic       core_nullified_in,
   input wire logic [5:0] core_addr_in,
   input wire logic [7:0] ext_state_out,
   input wire logic       inbound_pending_pin_out,
   input wire logic       outbound_pending_pin_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   wire logic hi = core_addr_in == mailbox_pkg::REG_DATA_HIGH;
   wire logic hw = mailbox_select_in & host_wr_in;
   wire logic hr = mailbox_select_in & host_rd_in;
   // a nullified read still counts as taking the word
   wire logic cr = core_rd_in & hi;
   wire logic cw = core_wr_in & hi & !core_nullified_in;
   wire logic ip = inbound_pending_pin_out;
   wire logic op = outbound_pending_pin_out;
   a_in_set: assert property (hw |=> ip) else $error("inbound not set");
   a_in_clear: assert property (cr && !hw |=> !ip) else $error("inbound stuck");
   a_in_hold: assert property (!hw && !cr |=> $stable(ip)) else $error("inbound moved");
   a_out_set: assert property (cw |=> op) else $error("outbound not set");
   a_out_clear: assert property (hr && !cw |=> !op) else $error("outbound stuck");
   a_out_hold: assert property (!hr && !cw |=> $stable(op)) else $error("outbound moved");
   a_state_map: assert property (ext_state_out == {op, ip, 6'h00}) else $error("bad state");
   a_reset_clear: assert property ($fell(rst_in) |-> !ip && !op) else $error("flag after reset");
   c_in: cover property (hw ##1 ip);
   c_out: cover property (cw ##1 op);
   c_null: cover property (cr && core_nullified_in && ip);
   c_race: cover property (hw && cr);
endmodule
bind host_core_mailbox mailbox_sva u_sva (.*);
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic        clock_in,
   input  wire logic        pend_in,
   output logic             sel_out,
   output logic             wr_out,
   output logic             rd_out,
   output logic      [31:0] wdata_out
);
   initial {sel_out, wr_out, rd_out, wdata_out} = '0;
   task automatic put(input logic [31:0] w);
      @(negedge clock_in);
      while (pend_in) @(negedge clock_in);
      {sel_out, wr_out, wdata_out} = {2'b11, w};
      @(negedge clock_in);
      // released bus shows the inverse so stale data cannot pass
      {sel_out, wr_out, wdata_out} = {2'b00, ~w};
   endtask
   task automatic get();
      @(negedge clock_in);
      {sel_out, rd_out} = 2'b11;
      @(negedge clock_in);
      {sel_out, rd_out} = 2'b00;
   endtask
endmodule
`default_nettype wire

// >>> tb/host_core_mailbox_bench.sv
`timescale 1ns/10ps
`default_nettype none
module host_core_mailbox_bench;
   logic clock_in = 0, rst_in = 1, cwr = 0, crd = 0, cnul = 0;
   logic [5:0] cad = 0;
   logic [15:0] cwd = 0;
   wire logic sel, hwr, hrd, ip, op;
   wire logic [31:0] hwd, hq;
   wire logic [15:0] cq;
   wire logic [7:0] ess;
   int mismatches = 0, checks_done = 0;
   always #50 clock_in = ~clock_in;
   host_model u_host (.clock_in, .pend_in(ip), .sel_out(sel), .wr_out(hwr), .rd_out(hrd),
      .wdata_out(hwd));
   host_core_mailbox u_dut (.clock_in, .rst_in, .mailbox_select_in(sel), .host_wr_in(hwr),
      .host_rd_in(hrd), .host_wdata_in(hwd), .host_rdata_out(hq), .core_wr_in(cwr),
      .core_rd_in(crd), .core_nullified_in(cnul), .core_addr_in(cad), .core_wdata_in(cwd),
      .core_rdata_out(cq), .ext_state_out(ess), .inbound_pending_pin_out(ip),
      .outbound_pending_pin_out(op));
   task automatic chk(input logic [39:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic core(input logic w, n, input logic [5:0] a, input logic [15:0] d);
      @(negedge clock_in);
      {cwr, crd, cnul, cad, cwd} = {w, !w, n, a, d};
      @(negedge clock_in);
      {cwr, crd, cnul, cwd} = {3'b000, ~d};
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // tests need about 35 cycles, so 1000 is ample
   initial
   begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      repeat (6) @(negedge clock_in);
      rst_in = 0;
      chk({ip, op, ess}, 0);
      u_host.put(32'h1234abcd);
      chk({ip, op, ess}, 10'h240);
      core(0, 0, 6'h29, 0);
      chk({ip, cq}, 17'h1abcd);
      core(0, 0, 6'h28, 0);
      chk({ip, cq}, 17'h01234);
      $display("inbound test done");
      core(1, 0, 6'h29, 16'h5a5a);
      chk(op, 0);
      core(1, 0, 6'h28, 16'hc3c3);
      chk({ip, op, ess}, 10'h180);
      u_host.get();
      chk({op, hq}, 33'h0c3c35a5a);
      $display("outbound test done");
      u_host.put(32'h0f0f0f0f);
      core(0, 1, 6'h28, 0);
      chk(ip, 0);
      core(1, 1, 6'h28, 16'hffff);
      core(1, 0, 6'h27, 16'hffff);
      chk(op, 0);
      $display("nullify test done");
      // same-cycle events: the raising side wins over the clearing side
      fork
         u_host.get();
         core(1, 0, 6'h28, 16'h7e7e);
      join
      chk({op, hq}, 33'h1c3c35a5a);
      fork
         u_host.put(32'h89ab4567);
         core(0, 0, 6'h28, 0);
      join
      chk({ip, cq}, 17'h10f0f);
      $display("race test done");
      @(negedge clock_in);
      rst_in = 1;
      @(negedge clock_in);
      chk({ip, op, ess, cq}, 0);
      rst_in = 0;
      u_host.put(32'h13572468);
      chk({ip, op, ess}, 10'h240);
      $display("reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
